// >>> glc_counter.sv
`timescale 1ns/1ns
// ****************************************************************
// Functional notes
// - high limit violated when count equals high and an up pulse arrives
// - low limit violated when count equals low and a down pulse arrives
// - high violation sets overflow flag, low violation sets underflow flag
// - controller clear bits clear the overflow and underflow flags
// - configuration selects stop or continue after a limit violation
// - on violation the counter loads the opposite limit either way, except zero on a one-time high violation
// - software gate follows the controller control bit
// - configured hardware gate is open while the delayed gate pin is high
// - closed hardware gate holds counter and ignores pulses
// - internal gate is software AND hardware; unconfigured hardware is open
// - internal gate state is reported as a status bit
// - pulses counted only while internal gate is open
// - stop-at-limit closes gate until a gate is closed and reopened
// - hardware gate input passes a configurable delay first
// - one-time mode stops at high violation and sets counter to zero
// - one-time restart needs hardware gate low then high again
// - compare-high: cmp0 <= count <= high sets compare output
// - compare-low: low <= count <= cmp0 sets compare output
// - window: cmp0 <= count <= cmp1 sets compare output
// - direction input 0 counts up, 1 counts down
// - start option: continue from count or load start value
// ****************************************************************
module glc_counter
(
   input  wire logic        clk,            // 100 MHz clock
   input  wire logic        rstn,           // sync reset, active low
   input  wire logic        psel,           // apb select
   input  wire logic        penable,        // apb enable
   input  wire logic        pwrite,         // apb direction
   input  wire logic [7:0]  paddr,          // apb byte address
   input  wire logic [31:0] pwdata,         // apb write data
   output logic      [31:0] prdata,         // apb read data
   output logic             pready,         // apb ready
   output logic             pslverr,        // apb error
   input  wire logic        count_pulse,    // one-cycle count pulse
   input  wire logic        direction_input,// 0 up, 1 down
   input  wire logic        gate_input_pin, // hardware gate level
   output logic             internal_gate_state,  // gate status
   output logic             compare_output_state, // compare status
   output logic             overflow_event_flag,  // sticky overflow
   output logic             underflow_event_flag  // sticky underflow
);
   localparam int W = glc_pkg::CNT_W;
   // ****************************************************************
   // register bank
   // ****************************************************************
   logic [31:0]  ctrl_reg;
   logic [W-1:0] high_reg, low_reg, start_reg, cmp0_reg, cmp1_reg;
   logic [glc_pkg::DLY_W-1:0] dly_reg;
   logic [W-1:0] count_reg, count_next;
   logic         stop_reg, stop_next;
   logic         hw_prev_reg, sw_prev_reg;
   logic         oflw_reg, uflw_reg;
   logic         cmp_reg;

   wire wr_en   = psel && penable && pwrite;
   wire hit_ctl = paddr == glc_pkg::OFS_CTRL;
   wire hit_hi  = paddr == glc_pkg::OFS_HIGH;
   wire hit_lo  = paddr == glc_pkg::OFS_LOW;
   wire hit_st  = paddr == glc_pkg::OFS_START;
   wire hit_c0  = paddr == glc_pkg::OFS_CMP0;
   wire hit_c1  = paddr == glc_pkg::OFS_CMP1;
   wire hit_dl  = paddr == glc_pkg::OFS_DELAY;
   wire hit_cmd = paddr == glc_pkg::OFS_CMD;
   wire hit_sts = paddr == glc_pkg::OFS_STATUS;
   wire hit_cnt = paddr == glc_pkg::OFS_COUNT;
   wire mapped  = hit_ctl | hit_hi | hit_lo | hit_st | hit_c0 | hit_c1
                | hit_dl | hit_cmd | hit_sts | hit_cnt;
   wire cmd_wr  = wr_en && hit_cmd;
   wire o_clr   = cmd_wr && pwdata[glc_pkg::C_OCLR];
   wire u_clr   = cmd_wr && pwdata[glc_pkg::C_UCLR];
   wire ld_cmd  = cmd_wr && pwdata[glc_pkg::C_LOAD];

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         ctrl_reg  <= 32'h00000000;
         high_reg  <= glc_pkg::RST_HIGH;
         low_reg   <= glc_pkg::RST_LOW;
         start_reg <= 32'h00000000;
         cmp0_reg  <= 32'h00000000;
         cmp1_reg  <= 32'h00000000;
         dly_reg   <= 8'h00;
      end
      else if (wr_en)
      begin
         if (hit_ctl) ctrl_reg  <= pwdata;
         if (hit_hi)  high_reg  <= pwdata;
         if (hit_lo)  low_reg   <= pwdata;
         if (hit_st)  start_reg <= pwdata;
         if (hit_c0)  cmp0_reg  <= pwdata;
         if (hit_c1)  cmp1_reg  <= pwdata;
         if (hit_dl)  dly_reg   <= pwdata[glc_pkg::DLY_W-1:0];
      end
   end

   wire software_gate_control  = ctrl_reg[glc_pkg::B_SWGATE];
   wire hw_en    = ctrl_reg[glc_pkg::B_HWEN];
   wire stop_lim = ctrl_reg[glc_pkg::B_STOPLIM];
   wire once     = ctrl_reg[glc_pkg::B_ONCE];
   wire dir_pin  = ctrl_reg[glc_pkg::B_DIRIN];
   wire dir_cfg  = ctrl_reg[glc_pkg::B_DIRCFG];
   wire ld_start = ctrl_reg[glc_pkg::B_LOADST];
   wire [3:0] cmp_mode = ctrl_reg[glc_pkg::B_CMPLO +: 4];

   // ****************************************************************
   // gate logic
   // ****************************************************************
   logic hw_dly;
   glc_delay u_dly
   (
      .clk     (clk),
      .rstn    (rstn),
      .dly_len (dly_reg),
      .din     (gate_input_pin),
      .dout    (hw_dly)
   );
   wire hardware_gate_input   = hw_en ? hw_dly : 1'b1;
   wire base_gate = software_gate_control && hardware_gate_input;
   wire gate_open = base_gate && !stop_reg;
   // a reopen of either gate releases a limit stop; one-time needs the hardware_gate_input
   wire hw_rise   = hardware_gate_input && !hw_prev_reg;
   wire sw_rise   = software_gate_control && !sw_prev_reg;
   wire reopen    = once ? hw_rise : (hw_rise || sw_rise);
   // an opening edge of the internal gate is a start command
   wire gate_rise = base_gate && !(sw_prev_reg && hw_prev_reg);

   // ****************************************************************
   // counting
   // ****************************************************************
   wire down   = dir_pin ? direction_input : dir_cfg;
   wire pulse  = count_pulse && gate_open;
   wire hi_vio = pulse && !down && count_reg == high_reg;
   wire lo_vio = pulse && down && count_reg == low_reg;

   always_comb
   begin
      count_next = count_reg;
      stop_next  = stop_reg;
      if (reopen)
         stop_next = 1'b0;
      if (ld_cmd || (gate_rise && ld_start))
         count_next = start_reg;
      else if (hi_vio)
      begin
         count_next = once ? glc_pkg::ONCE_LOW : low_reg;
         if (stop_lim || once)
            stop_next = 1'b1;
      end
      else if (lo_vio)
      begin
         count_next = high_reg;
         if (stop_lim)
            stop_next = 1'b1;
      end
      else if (pulse)
         count_next = down ? count_reg - 32'h1 : count_reg + 32'h1;
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         count_reg   <= 32'h00000000;
         stop_reg    <= 1'b0;
         // an unconfigured hardware_gate_input idles open, so no false rise after reset
         hw_prev_reg <= 1'b1;
         sw_prev_reg <= 1'b0;
      end
      else
      begin
         count_reg   <= count_next;
         stop_reg    <= stop_next;
         hw_prev_reg <= hardware_gate_input;
         sw_prev_reg <= software_gate_control;
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         oflw_reg <= 1'b0;
         uflw_reg <= 1'b0;
      end
      else
      begin
         oflw_reg <= hi_vio || (oflw_reg && !o_clr);
         uflw_reg <= lo_vio || (uflw_reg && !u_clr);
      end
   end

   // ****************************************************************
   // comparison
   // ****************************************************************
   wire ge_c0 = count_reg >= cmp0_reg;
   wire le_c0 = count_reg <= cmp0_reg;
   wire le_c1 = count_reg <= cmp1_reg;
   wire in_hi = ge_c0 && count_reg <= high_reg;
   wire in_lo = count_reg >= low_reg && le_c0;
   wire in_wn = ge_c0 && le_c1;
   logic cmp_val;
   always_comb
   begin
      unique case (cmp_mode)
         glc_pkg::CMP_HIGH: cmp_val = in_hi;
         glc_pkg::CMP_LOW:  cmp_val = in_lo;
         glc_pkg::CMP_WIN:  cmp_val = in_wn;
         glc_pkg::CMP_NWIN: cmp_val = !in_wn;
         default:           cmp_val = 1'b0;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         cmp_reg             <= 1'b0;
         internal_gate_state <= 1'b0;
      end
      else
      begin
         cmp_reg             <= cmp_val;
         internal_gate_state <= gate_open;
      end
   end

   assign compare_output_state = cmp_reg;
   assign overflow_event_flag  = oflw_reg;
   assign underflow_event_flag = uflw_reg;

   wire [31:0] status_w = {27'h0, stop_reg, cmp_reg, internal_gate_state,
                           uflw_reg, oflw_reg};
   always_comb
   begin
      prdata = 32'h00000000;
      if (psel && !pwrite)
      begin
         if (hit_ctl) prdata = ctrl_reg;
         if (hit_hi)  prdata = high_reg;
         if (hit_lo)  prdata = low_reg;
         if (hit_st)  prdata = start_reg;
         if (hit_c0)  prdata = cmp0_reg;
         if (hit_c1)  prdata = cmp1_reg;
         if (hit_dl)  prdata = {24'h0, dly_reg};
         if (hit_sts) prdata = status_w;
         if (hit_cnt) prdata = count_reg;
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   property p_ovf_set;
      @(posedge clk) disable iff (!rstn) hi_vio |=> overflow_event_flag;
   endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("overflow not set");
   property p_unf_set;
      @(posedge clk) disable iff (!rstn) lo_vio |=> underflow_event_flag;
   endproperty
   a_unf_set: assert property (p_unf_set) else $error("underflow not set");
   property p_ovf_clr;
      @(posedge clk) disable iff (!rstn) (o_clr && !hi_vio) |=> !overflow_event_flag;
   endproperty
   a_ovf_clr: assert property (p_ovf_clr) else $error("overflow not cleared");
   property p_hold;
      @(posedge clk) disable iff (!rstn)
         (!gate_open && !ld_cmd && !(gate_rise && ld_start)) |=> $stable(count_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("count moved while gated");
   property p_wrap_hi;
      @(posedge clk) disable iff (!rstn)
         (hi_vio && !once && !ld_cmd && !(gate_rise && ld_start))
         |=> count_reg == $past(low_reg);
   endproperty
   a_wrap_hi: assert property (p_wrap_hi) else $error("no low limit load");
   property p_once;
      @(posedge clk) disable iff (!rstn)
         (hi_vio && once && !ld_cmd && !(gate_rise && ld_start))
         |=> count_reg == 32'h0 && stop_reg;
   endproperty
   a_once: assert property (p_once) else $error("one-time stop wrong");
   property p_stop;
      @(posedge clk) disable iff (!rstn)
         ((hi_vio || lo_vio) && stop_lim && !reopen) |=> !gate_open;
   endproperty
   a_stop: assert property (p_stop) else $error("gate not closed at limit");
   property p_up;
      @(posedge clk) disable iff (!rstn)
         (pulse && !down && !hi_vio && !ld_cmd && !(gate_rise && ld_start))
         |=> count_reg == $past(count_reg) + 32'h1;
   endproperty
   a_up: assert property (p_up) else $error("up count wrong");
   property p_gate;
      @(posedge clk) disable iff (!rstn) (hw_en && !hw_dly) |=> !internal_gate_state;
   endproperty
   a_gate: assert property (p_gate) else $error("gate open with hw low");
   property p_unf_clr;
      @(posedge clk) disable iff (!rstn) (u_clr && !lo_vio) |=> !underflow_event_flag;
   endproperty
   a_unf_clr: assert property (p_unf_clr) else $error("underflow not cleared");
   property p_wrap_lo;
      @(posedge clk) disable iff (!rstn)
         (lo_vio && !ld_cmd && !(gate_rise && ld_start))
         |=> count_reg == $past(high_reg);
   endproperty
   a_wrap_lo: assert property (p_wrap_lo) else $error("no high limit load");
   property p_down;
      @(posedge clk) disable iff (!rstn)
         (pulse && down && !lo_vio && !ld_cmd && !(gate_rise && ld_start))
         |=> count_reg == $past(count_reg) - 32'h1;
   endproperty
   a_down: assert property (p_down) else $error("down count wrong");
   property p_sw_off;
      @(posedge clk) disable iff (!rstn) !software_gate_control |=> !internal_gate_state;
   endproperty
   a_sw_off: assert property (p_sw_off) else $error("gate open with sw low");
   property p_win;
      @(posedge clk) disable iff (!rstn)
         (cmp_mode == glc_pkg::CMP_WIN && count_reg >= cmp0_reg && count_reg <= cmp1_reg)
         |=> compare_output_state;
   endproperty
   a_win: assert property (p_win) else $error("window compare not set");
   property p_nwin;
      @(posedge clk) disable iff (!rstn)
         (cmp_mode == glc_pkg::CMP_NWIN && count_reg >= cmp0_reg && count_reg <= cmp1_reg)
         |=> !compare_output_state;
   endproperty
   a_nwin: assert property (p_nwin) else $error("inverted window set inside");
   property p_keep;
      @(posedge clk) disable iff (!rstn) (stop_reg && !hw_rise && !sw_rise) |=> stop_reg;
   endproperty
   a_keep: assert property (p_keep) else $error("limit stop released early");
   property p_once_keep;
      @(posedge clk) disable iff (!rstn) (stop_reg && once && !hw_rise) |=> stop_reg;
   endproperty
   a_once_keep: assert property (p_once_keep) else $error("one-time restart early");
   c_ovf:  cover property (@(posedge clk) disable iff (!rstn) hi_vio);
   c_unf:  cover property (@(posedge clk) disable iff (!rstn) lo_vio);
   c_cmp:  cover property (@(posedge clk) disable iff (!rstn) $rose(compare_output_state));
   c_rel:  cover property (@(posedge clk) disable iff (!rstn) stop_reg && reopen);
endmodule // glc_counter

// >>> glc_delay.sv
`timescale 1ns/1ns
// programmable input delay: a level must hold dly_len+2 cycles before it passes
module glc_delay
(
   input  wire logic                     clk,     // system clock
   input  wire logic                     rstn,    // sync reset, active low
   input  wire logic [glc_pkg::DLY_W-1:0] dly_len, // delay in cycles
   input  wire logic                     din,     // raw level
   output logic                          dout     // delayed level
);
   logic [glc_pkg::DLY_W-1:0] cnt_reg;
   logic                      last_reg;
   wire                       changed = din != last_reg;
   wire                       expired = cnt_reg >= dly_len;

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         cnt_reg  <= 8'h00;
         last_reg <= 1'b0;
         dout     <= 1'b0;
      end
      else
      begin
         last_reg <= din;
         if (changed)
            cnt_reg <= 8'h00;
         else if (!expired)
            cnt_reg <= cnt_reg + 8'h01;
         if (!changed && expired)
            dout <= din;
      end
   end
endmodule // glc_delay

// >>> glc_pkg.sv
package glc_pkg;
   localparam int unsigned CNT_W = 32;
   localparam int unsigned DLY_W = 8;
   localparam int unsigned NCHAN = 2;
   localparam int unsigned FPERIOD = 32;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_HIGH   = 8'h04;
   localparam logic [7:0] OFS_LOW    = 8'h08;
   localparam logic [7:0] OFS_START  = 8'h0c;
   localparam logic [7:0] OFS_CMP0   = 8'h10;
   localparam logic [7:0] OFS_CMP1   = 8'h14;
   localparam logic [7:0] OFS_DELAY  = 8'h18;
   localparam logic [7:0] OFS_CMD    = 8'h1c;
   localparam logic [7:0] OFS_STATUS = 8'h20;
   localparam logic [7:0] OFS_COUNT  = 8'h24;
   // ctrl field positions
   localparam int unsigned B_SWGATE   = 0;
   localparam int unsigned B_HWEN     = 1;
   localparam int unsigned B_STOPLIM  = 2;
   localparam int unsigned B_ONCE     = 3;
   localparam int unsigned B_DIRIN    = 4;
   localparam int unsigned B_DIRCFG   = 5;
   localparam int unsigned B_LOADST   = 6;
   localparam int unsigned B_CMPLO    = 8;
   // cmd bits (write one)
   localparam int unsigned C_OCLR = 0;
   localparam int unsigned C_UCLR = 1;
   localparam int unsigned C_LOAD = 2;
   // status bits
   localparam int unsigned S_OFLW = 0;
   localparam int unsigned S_UFLW = 1;
   localparam int unsigned S_GATE = 2;
   localparam int unsigned S_CMP  = 3;
   localparam int unsigned S_STOP = 4;
   localparam logic [CNT_W-1:0] RST_HIGH  = 32'h7fffffff;
   localparam logic [CNT_W-1:0] RST_LOW   = 32'h00000000;
   localparam logic [CNT_W-1:0] ONCE_LOW  = 32'h00000000;
   typedef enum logic [3:0]
   {
      CMP_HIGH = 4'h1,
      CMP_LOW  = 4'h2,
      CMP_WIN  = 4'h4,
      CMP_NWIN = 4'h8
   } glc_cmp_t;
endpackage

// >>> glc_src.sv
`timescale 1ns/1ns
// ****************************************
// pulse encoder and gate/direction source
// ****************************************
module glc_src
(
   input  wire logic       clk,             // clock
   input  wire logic       rstn,            // sync reset, active low
   input  wire logic       go,              // start a burst
   input  wire logic [7:0] num,             // pulses in the burst
   input  wire logic [1:0] gap,             // idle cycles between pulses
   input  wire logic       dir_cmd,         // wanted direction level
   input  wire logic       gate_cmd,        // wanted gate level
   output logic            count_pulse,     // one-cycle count pulse
   output logic            direction_input, // direction level
   output logic            gate_input_pin,  // gate level
   output logic            busy             // burst in progress
);
   logic [7:0] left_reg;
   logic [1:0] wait_reg;
   wire        fire = (left_reg != 8'h00) && (wait_reg == 2'h0);
   assign busy = (left_reg != 8'h00) || go;
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         left_reg        <= 8'h00;
         wait_reg        <= 2'h0;
         count_pulse     <= 1'b0;
         direction_input <= 1'b0;
         gate_input_pin  <= 1'b0;
      end
      else
      begin
         // levels move only on edges, like a real encoder sampled here
         direction_input <= dir_cmd;
         gate_input_pin  <= gate_cmd;
         count_pulse     <= fire && !go;
         left_reg        <= go ? num : (fire ? left_reg - 8'h01 : left_reg);
         wait_reg        <= go ? 2'h0 : (fire ? gap : wait_reg - {1'b0, wait_reg != 2'h0});
      end
   end
endmodule // glc_src

// >>> tb_gated_limit_counter_compare.sv
`timescale 1ns/1ns
module tb_gated_limit_counter_compare;
   localparam logic [31:0] SW  = 32'h1 << glc_pkg::B_SWGATE;
   localparam logic [31:0] HW  = 32'h1 << glc_pkg::B_HWEN;
   localparam logic [31:0] STP = 32'h1 << glc_pkg::B_STOPLIM;
   localparam logic [31:0] ONE = 32'h1 << glc_pkg::B_ONCE;
   localparam logic [31:0] DIN = 32'h1 << glc_pkg::B_DIRIN;
   localparam logic [31:0] DCF = 32'h1 << glc_pkg::B_DIRCFG;
   localparam logic [31:0] LDS = 32'h1 << glc_pkg::B_LOADST;
   localparam logic [31:0] LO  = 32'h0000000a;
   localparam logic [31:0] HI  = 32'h000000c8;
   logic        clk, rstn, psel, penable, pwrite, go, dir_c, gate_c;
   logic        pready, pslverr, cp, di, gp, gs, cs, ov, un, busy, e;
   logic [7:0]  paddr, num;
   logic [1:0]  gap;
   logic [31:0] pwdata, prdata, q, c0, c1, n;
   logic [31:0] cand [7];
   int          fails, checks_done, m, j;
   glc_counter u_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .count_pulse(cp), .direction_input(di), .gate_input_pin(gp), .internal_gate_state(gs),
      .compare_output_state(cs), .overflow_event_flag(ov), .underflow_event_flag(un));
   glc_src u_src (.clk(clk), .rstn(rstn), .go(go), .num(num), .gap(gap), .dir_cmd(dir_c),
      .gate_cmd(gate_c), .count_pulse(cp), .direction_input(di), .gate_input_pin(gp),
      .busy(busy));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic cmp_exp(input logic [3:0] md, input logic [31:0] c);
      case (md)
         glc_pkg::CMP_HIGH: return (c0 <= c) && (c <= HI);
         glc_pkg::CMP_LOW:  return (LO <= c) && (c <= c0);
         glc_pkg::CMP_WIN:  return (c0 <= c) && (c <= c1);
         default:           return !((c0 <= c) && (c <= c1));
      endcase
   endfunction
   task results();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task tmo();
      fails++;
      results();
   endtask
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // every transfer starts on the first edge after the apb task is called
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      for (i = 0; i < 16 && pready !== 1'b1; i++)
         @(posedge clk);
      if (i == 16)
         tmo();
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input string nm, input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      check(nm, q, x);
   endtask
   task cnt(input logic [31:0] x);
      rd("count", glc_pkg::OFS_COUNT, x);
   endtask
   task ld(input logic [31:0] v);
      wr(glc_pkg::OFS_START, v);
      wr(glc_pkg::OFS_CMD, 32'h1 << glc_pkg::C_LOAD);
   endtask
   task flg(input logic o, input logic u);
      @(posedge clk);
      check("ovf", {31'h0, ov}, {31'h0, o});
      check("unf", {31'h0, un}, {31'h0, u});
   endtask
   task wgate(input logic v);
      int i;
      for (i = 0; i < 60 && gs !== v; i++)
         @(posedge clk);
      if (i == 60)
         tmo();
   endtask
   task pul(input int k);
      int i;
      @(posedge clk);
      num <= 8'(k);
      gap <= 2'($urandom_range(3));
      go  <= 1'b1;
      @(posedge clk);
      go  <= 1'b0;
      for (i = 0; i < 300 && busy === 1'b1; i++)
         @(posedge clk);
      if (i == 300)
         tmo();
      repeat (3) @(posedge clk);
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      fails = 0;
      checks_done = 0;
      {rstn, psel, penable, pwrite, go, dir_c, gate_c} = 7'h00;
      {paddr, num, gap, pwdata} = 50'h0;
      void'($urandom(97152));
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      rd("high", glc_pkg::OFS_HIGH, glc_pkg::RST_HIGH);
      rd("status", glc_pkg::OFS_STATUS, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      check("slverr", {31'h0, e}, 32'h1);
      wr(glc_pkg::OFS_HIGH, 32'h3e8);
      wr(glc_pkg::OFS_CTRL, SW);
      wgate(1'b1);
      n = $urandom_range(40, 1);
      pul(n);
      cnt(n);
      wr(glc_pkg::OFS_CTRL, 32'h0);
      wgate(1'b0);
      pul(5);
      cnt(n);
      wr(glc_pkg::OFS_HIGH, 32'h14);
      wr(glc_pkg::OFS_LOW, 32'h5);
      ld(32'h12);
      wr(glc_pkg::OFS_CTRL, SW);
      pul(2);
      flg(1'b0, 1'b0);
      pul(1);
      cnt(32'h5);
      flg(1'b1, 1'b0);
      wr(glc_pkg::OFS_CMD, 32'h1 << glc_pkg::C_OCLR);
      flg(1'b0, 1'b0);
      wr(glc_pkg::OFS_CTRL, SW | DCF);
      ld(32'h6);
      pul(2);
      cnt(32'h14);
      flg(1'b0, 1'b1);
      wr(glc_pkg::OFS_CMD, 32'h1 << glc_pkg::C_UCLR);
      flg(1'b0, 1'b0);
      wr(glc_pkg::OFS_CTRL, SW | STP);
      ld(32'h14);
      pul(1);
      wgate(1'b0);
      rd("status", glc_pkg::OFS_STATUS, 32'h11);
      pul(2);
      cnt(32'h5);
      wr(glc_pkg::OFS_CTRL, STP);
      wr(glc_pkg::OFS_CTRL, SW | STP);
      wgate(1'b1);
      pul(1);
      cnt(32'h6);
      wr(glc_pkg::OFS_DELAY, 32'h4);
      wr(glc_pkg::OFS_CTRL, SW | HW);
      pul(3);
      cnt(32'h6);
      gate_c <= 1'b1;
      // without the programmed delay the gate would already show open here
      repeat (6) @(posedge clk);
      check("gate", {31'h0, gs}, 32'h0);
      wgate(1'b1);
      pul(3);
      cnt(32'h9);
      gate_c <= 1'b0;
      wgate(1'b0);
      pul(2);
      cnt(32'h9);
      wr(glc_pkg::OFS_CTRL, SW | HW | ONE);
      ld(32'h13);
      gate_c <= 1'b1;
      wgate(1'b1);
      pul(2);
      cnt(glc_pkg::ONCE_LOW);
      wr(glc_pkg::OFS_CTRL, HW | ONE);
      wr(glc_pkg::OFS_CTRL, SW | HW | ONE);
      pul(1);
      cnt(glc_pkg::ONCE_LOW);
      gate_c <= 1'b0;
      repeat (12) @(posedge clk);
      gate_c <= 1'b1;
      wgate(1'b1);
      pul(1);
      cnt(32'h1);
      wr(glc_pkg::OFS_HIGH, 32'h3e8);
      wr(glc_pkg::OFS_CTRL, SW | DIN | DCF);
      ld(32'h64);
      dir_c <= 1'b1;
      pul(3);
      cnt(32'h61);
      dir_c <= 1'b0;
      pul(2);
      cnt(32'h63);
      wr(glc_pkg::OFS_CTRL, 32'h0);
      wr(glc_pkg::OFS_START, 32'h12c);
      wr(glc_pkg::OFS_CTRL, SW | LDS);
      wgate(1'b1);
      cnt(32'h12c);
      wr(glc_pkg::OFS_CTRL, 32'h0);
      wr(glc_pkg::OFS_CTRL, SW);
      pul(1);
      cnt(32'h12d);
      wr(glc_pkg::OFS_HIGH, HI);
      wr(glc_pkg::OFS_LOW, LO);
      // boundaries of each window, plus one random point inside the limits
      for (m = 0; m < 4; m++)
         for (j = 0; j < 7; j++)
         begin
            c0 = 32'h20 + $urandom_range(31);
            c1 = c0 + 32'h1 + $urandom_range(63);
            cand = '{c0 - 32'h1, c0, c1, c1 + 32'h1, LO, HI, $urandom_range(HI, LO)};
            wr(glc_pkg::OFS_CTRL, 32'h1 << (glc_pkg::B_CMPLO + m));
            wr(glc_pkg::OFS_CMP0, c0);
            wr(glc_pkg::OFS_CMP1, c1);
            ld(cand[j]);
            repeat (3) @(posedge clk);
            check("cmp", {31'h0, cs}, {31'h0, cmp_exp(4'h1 << m, cand[j])});
         end
      results();
   end
endmodule // tb_gated_limit_counter_compare
